/* rtl/odt_pkg.sv */
/*
  Constants, register map and types for the odometer input and time
  tagging block. Assumes a single system clock and a plain register port.
*/
`default_nettype none
package odt_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_LIMIT = 8'h04;
  localparam logic [7:0] ADR_LAT = 8'h08;
  localparam logic [7:0] ADR_RATE = 8'h0C;
  localparam logic [7:0] ADR_TTFACT = 8'h10;
  localparam logic [7:0] ADR_TTMAX = 8'h14;
  localparam logic [7:0] ADR_STAT = 8'h18;
  localparam logic [7:0] ADR_TICKS = 8'h1C;
  localparam logic [7:0] ADR_SAMPLE = 8'h20;
  localparam logic [7:0] ADR_STAMP = 8'h24;
  localparam logic [7:0] ADR_QERR = 8'h28;
  localparam logic [7:0] ADR_SCALE = 8'h2C;
  // Control bit positions
  localparam int B_PIN_EN = 0;
  localparam int B_APOL_DIS = 1;
  localparam int B_DIR_POL = 2;
  localparam int B_DUAL = 3;
  localparam int B_AMSG_DIS = 4;
  localparam int B_COMBINE = 5;
  localparam int B_ALIM_DIS = 6;
  localparam int B_USE_SPD = 7;
  localparam int B_ASPD_DIS = 8;
  localparam int B_TMARK_MODE = 9;
  localparam int B_TP1_EN = 10;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // Message data types
  localparam logic [5:0] TYPE_TICK = 6'h0A;
  localparam logic [5:0] TYPE_SPEED = 6'h0B;
  localparam logic [31:0] LIMIT_REL = 32'h0000_0000;
  localparam logic [31:0] LIMIT_AUTO = 32'h0000_0001;
  localparam logic [31:0] TTFACT_RST = 32'h0000_03E8;
  localparam logic [31:0] TTMAX_RST = 32'hFFFF_FFFF;
  // Time tag tick: one millisecond
  localparam int CLK_HZ = 40000000;
  localparam int TTAG_US = 1000;
  localparam int TTAG_CYC = CLK_HZ / 1000000 * TTAG_US;
  localparam logic [15:0] TTAG_CYC_M1 = 16'(TTAG_CYC - 1);
  localparam logic [31:0] RATE_WIN_MS = 32'h0000_03E8;
  typedef enum logic [1:0] {
    SRC_NONE, SRC_PIN, SRC_MSG_TICK, SRC_MSG_SPEED
  } odt_src_t;
endpackage
`default_nettype wire

/* rtl/odt_top.sv */
/*
  Odometer front end: tick pin counting, message sample intake, source
  selection and millisecond time tagging. Assumes pins are asynchronous
  and messages arrive as parsed samples with a first byte strobe.
*/
`default_nettype none
module odt_top (
  input wire logic CLK_SYS_I,
  input wire logic RESET_I,
  input wire logic TICK_PIN_I,
  input wire logic DIR_PIN_I,
  input wire logic EXT_MARK_I,
  input wire logic MSG_FIRST_I,
  input wire logic MSG_VALID_I,
  input wire logic [5:0] MSG_TYPE_I,
  input wire logic MSG_REAR_I,
  input wire logic [23:0] MSG_DATA_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  output logic SAMPLE_O,
  output logic [31:0] SAMPLE_DATA_O,
  output logic SAMPLE_SPEED_O,
  output logic [31:0] STAMP_O,
  output logic MARKED_O
);
  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  logic [2:0] s1_r, s2_r, s3_r;
  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      s1_r <= 3'h0;
      s2_r <= 3'h0;
      s3_r <= 3'h0;
    end else begin
      s1_r <= {EXT_MARK_I, DIR_PIN_I, TICK_PIN_I};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  wire logic dir_s = s2_r[1];
  wire logic rise = s2_r[0] & ~s3_r[0];
  wire logic fall = ~s2_r[0] & s3_r[0];
  wire logic mark_pin = s2_r[2] & ~s3_r[2];

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_r, ctrl_nxt, lim_r, lim_nxt, lat_r, lat_nxt;
  logic [31:0] rate_r, rate_nxt, fact_r, fact_nxt, tmax_r, tmax_nxt;
  logic [31:0] qerr_r, qerr_nxt, scale_r, scale_nxt;
  logic [31:0] pin_cnt_r, pin_cnt_nxt, ms_r, ms_nxt, stamp_r, stamp_nxt;
  logic [31:0] samp_r, samp_nxt, prev_r, prev_nxt, est_r, est_nxt;
  logic [31:0] rate_cnt_r, rate_cnt_nxt, win_r, win_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [15:0] div_r, div_nxt;
  logic seen_tick_r, seen_tick_nxt, seen_spd_r, seen_spd_nxt;
  logic pend_r, pend_nxt, mark_r, mark_nxt, samp_v_r, samp_v_nxt;
  logic spd_r, spd_nxt, apol_r, apol_nxt, rate_ok_r, rate_ok_nxt;
  logic have_prev_r, have_prev_nxt;
  logic [31:0] first_ms_r, first_ms_nxt, mark_ms_r, mark_ms_nxt;
  odt_pkg::odt_src_t src;

  logic pin_en, pol, use_spd_eff, msg_any, tick_ev, ms_tick, seen_t, seen_s;
  logic [31:0] wrap, delta, abs_v, lim_eff, base;
  always_comb begin
    pin_en = ctrl_r[odt_pkg::B_PIN_EN];
    // Automatic polarity learnt from the level while ticks arrive
    pol = ctrl_r[odt_pkg::B_APOL_DIS] ?
      ctrl_r[odt_pkg::B_DIR_POL] : apol_r;
    // The message that reveals a source is already routed to it
    seen_t = seen_tick_r | (MSG_VALID_I && MSG_TYPE_I == odt_pkg::TYPE_TICK);
    seen_s = seen_spd_r | (MSG_VALID_I && MSG_TYPE_I == odt_pkg::TYPE_SPEED);
    msg_any = seen_t | seen_s;
    // Speed only: automatic unless disabled, else use_speed decides
    if (seen_s && !seen_t && !ctrl_r[odt_pkg::B_ASPD_DIS])
      use_spd_eff = 1'b1;
    else
      use_spd_eff = ctrl_r[odt_pkg::B_USE_SPD];
    if (msg_any && !ctrl_r[odt_pkg::B_AMSG_DIS])
      src = use_spd_eff ? odt_pkg::SRC_MSG_SPEED :
        odt_pkg::SRC_MSG_TICK;
    else if (pin_en)
      src = odt_pkg::SRC_PIN;
    else
      src = odt_pkg::SRC_NONE;
    tick_ev = pin_en && (rise ||
      (ctrl_r[odt_pkg::B_DUAL] && fall));
    ms_tick = (div_r == odt_pkg::TTAG_CYC_M1);
    // Auto estimate: seen count ORed with itself shifted right by 1, 2, 4, 8 and 16
    lim_eff = (lim_r == odt_pkg::LIMIT_AUTO &&
      !ctrl_r[odt_pkg::B_ALIM_DIS]) ? est_r : lim_r;
    abs_v = {8'h00, MSG_DATA_I};
    if (abs_v >= prev_r)
      delta = abs_v - prev_r;
    else
      delta = abs_v + (lim_eff - prev_r) + 32'h0000_0001;
    wrap = tmax_r;
    base = ctrl_r[odt_pkg::B_TMARK_MODE] ? mark_ms_r : first_ms_r;
  end

  logic mark_src;
  always_comb begin
    // Tick pin doubles as mark input only with tick use off
    mark_src = ctrl_r[odt_pkg::B_TP1_EN] && !pin_en ?
      (mark_pin | (s2_r[0] & ~s3_r[0])) : mark_pin;
    ctrl_nxt = ctrl_r;
    lim_nxt = lim_r;
    lat_nxt = lat_r;
    rate_nxt = rate_r;
    fact_nxt = fact_r;
    tmax_nxt = tmax_r;
    qerr_nxt = qerr_r;
    scale_nxt = scale_r;
    if (WR_I) begin
      case (ADDR_I)
        odt_pkg::ADR_CTRL: ctrl_nxt = WDATA_I;
        odt_pkg::ADR_LIMIT: lim_nxt = WDATA_I;
        odt_pkg::ADR_LAT: lat_nxt = WDATA_I;
        odt_pkg::ADR_RATE: rate_nxt = WDATA_I;
        odt_pkg::ADR_TTFACT: fact_nxt = WDATA_I;
        odt_pkg::ADR_TTMAX: tmax_nxt = WDATA_I;
        odt_pkg::ADR_QERR: qerr_nxt = WDATA_I;
        odt_pkg::ADR_SCALE: scale_nxt = WDATA_I;
        default: ctrl_nxt = ctrl_r;
      endcase
    end
    // Millisecond clock wraps at the configured maximum
    div_nxt = ms_tick ? 16'h0000 : div_r + 16'h0001;
    ms_nxt = ms_r;
    if (ms_tick)
      ms_nxt = (ms_r >= wrap) ? 32'h0000_0000 :
        ms_r + 32'h0000_0001;
    pin_cnt_nxt = pin_cnt_r;
    apol_nxt = apol_r;
    if (tick_ev && src == odt_pkg::SRC_PIN) begin
      pin_cnt_nxt = (dir_s ^ pol) ? pin_cnt_r - 32'h0000_0001 :
        pin_cnt_r + 32'h0000_0001;
    end
    // Forward assumed as the prevailing direction level
    if (rise && !ctrl_r[odt_pkg::B_APOL_DIS])
      apol_nxt = dir_s;
    first_ms_nxt = MSG_FIRST_I ? ms_r : first_ms_r;
    pend_nxt = pend_r;
    mark_ms_nxt = mark_ms_r;
    if (mark_src) begin
      pend_nxt = 1'b1;
      mark_ms_nxt = ms_r;
    end
    seen_tick_nxt = seen_tick_r;
    seen_spd_nxt = seen_spd_r;
    samp_v_nxt = 1'b0;
    samp_nxt = samp_r;
    spd_nxt = spd_r;
    stamp_nxt = stamp_r;
    mark_nxt = mark_r;
    prev_nxt = prev_r;
    have_prev_nxt = have_prev_r;
    est_nxt = est_r;
    if (MSG_VALID_I) begin
      if (MSG_TYPE_I == odt_pkg::TYPE_TICK)
        seen_tick_nxt = 1'b1;
      if (MSG_TYPE_I == odt_pkg::TYPE_SPEED)
        seen_spd_nxt = 1'b1;
    end
    if (MSG_VALID_I && (
        (src == odt_pkg::SRC_MSG_TICK && MSG_TYPE_I == odt_pkg::TYPE_TICK &&
         MSG_REAR_I == ctrl_r[odt_pkg::B_COMBINE]) ||
        (src == odt_pkg::SRC_MSG_SPEED &&
         MSG_TYPE_I == odt_pkg::TYPE_SPEED))) begin
      samp_v_nxt = 1'b1;
      spd_nxt = (MSG_TYPE_I == odt_pkg::TYPE_SPEED);
      stamp_nxt = base - lat_r;
      mark_nxt = ctrl_r[odt_pkg::B_TMARK_MODE] & pend_r;
      // A mark in the same cycle belongs to the next message: set wins
      if (ctrl_r[odt_pkg::B_TMARK_MODE] && !mark_src)
        pend_nxt = 1'b0;
      if (MSG_TYPE_I == odt_pkg::TYPE_SPEED || lim_r == odt_pkg::LIMIT_REL)
        samp_nxt = abs_v;
      else begin
        samp_nxt = have_prev_r ? delta : 32'h0000_0000;
        prev_nxt = abs_v;
        have_prev_nxt = 1'b1;
        if (abs_v > est_r)
          est_nxt = (abs_v | (abs_v >> 1) | (abs_v >> 2) | (abs_v >> 4) |
            (abs_v >> 8) | (abs_v >> 16));
      end
    end else if (ms_tick && src == odt_pkg::SRC_PIN &&
        div_r == odt_pkg::TTAG_CYC_M1 && ms_r[6:0] == 7'h00) begin
      // Pin source reports accumulated ticks every 128 ms
      samp_v_nxt = 1'b1;
      samp_nxt = pin_cnt_r;
      spd_nxt = 1'b0;
      stamp_nxt = ms_r - lat_r;
      mark_nxt = 1'b0;
    end
    // Sample rate measured over one second when unset
    rate_cnt_nxt = rate_cnt_r;
    win_nxt = win_r;
    rate_ok_nxt = rate_ok_r;
    if (rate_r == 32'h0000_0000 && !rate_ok_r) begin
      if (samp_v_nxt)
        rate_cnt_nxt = rate_cnt_r + 32'h0000_0001;
      if (ms_tick)
        win_nxt = win_r + 32'h0000_0001;
      if (win_r == odt_pkg::RATE_WIN_MS) begin
        rate_nxt = rate_cnt_r;
        rate_ok_nxt = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (RD_I) begin
      case (ADDR_I)
        odt_pkg::ADR_CTRL: rdata_nxt = ctrl_r;
        odt_pkg::ADR_LIMIT: rdata_nxt = lim_eff;
        odt_pkg::ADR_LAT: rdata_nxt = lat_r;
        odt_pkg::ADR_RATE: rdata_nxt = rate_r;
        odt_pkg::ADR_TTFACT: rdata_nxt = fact_r;
        odt_pkg::ADR_TTMAX: rdata_nxt = tmax_r;
        odt_pkg::ADR_STAT: rdata_nxt = {24'h000000, rate_ok_r,
          qerr_r == 32'h0000_0000, scale_r == 32'h0000_0000,
          pend_r, seen_spd_r, seen_tick_r, src};
        odt_pkg::ADR_TICKS: rdata_nxt = pin_cnt_r;
        odt_pkg::ADR_SAMPLE: rdata_nxt = samp_r;
        odt_pkg::ADR_STAMP: rdata_nxt = stamp_r;
        odt_pkg::ADR_QERR: rdata_nxt = qerr_r;
        odt_pkg::ADR_SCALE: rdata_nxt = scale_r;
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      ctrl_r <= odt_pkg::CTRL_RST;
      lim_r <= odt_pkg::LIMIT_REL;
      lat_r <= 32'h0000_0000;
      rate_r <= 32'h0000_0000;
      fact_r <= odt_pkg::TTFACT_RST;
      tmax_r <= odt_pkg::TTMAX_RST;
      qerr_r <= 32'h0000_0000;
      scale_r <= 32'h0000_0000;
      div_r <= 16'h0000;
      ms_r <= 32'h0000_0000;
      pin_cnt_r <= 32'h0000_0000;
      apol_r <= 1'b0;
      first_ms_r <= 32'h0000_0000;
      mark_ms_r <= 32'h0000_0000;
      pend_r <= 1'b0;
      seen_tick_r <= 1'b0;
      seen_spd_r <= 1'b0;
      samp_v_r <= 1'b0;
      samp_r <= 32'h0000_0000;
      spd_r <= 1'b0;
      stamp_r <= 32'h0000_0000;
      mark_r <= 1'b0;
      prev_r <= 32'h0000_0000;
      have_prev_r <= 1'b0;
      est_r <= 32'h0000_0000;
      rate_cnt_r <= 32'h0000_0000;
      win_r <= 32'h0000_0000;
      rate_ok_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ctrl_r <= ctrl_nxt;
      lim_r <= lim_nxt;
      lat_r <= lat_nxt;
      rate_r <= rate_nxt;
      fact_r <= fact_nxt;
      tmax_r <= tmax_nxt;
      qerr_r <= qerr_nxt;
      scale_r <= scale_nxt;
      div_r <= div_nxt;
      ms_r <= ms_nxt;
      pin_cnt_r <= pin_cnt_nxt;
      apol_r <= apol_nxt;
      first_ms_r <= first_ms_nxt;
      mark_ms_r <= mark_ms_nxt;
      pend_r <= pend_nxt;
      seen_tick_r <= seen_tick_nxt;
      seen_spd_r <= seen_spd_nxt;
      samp_v_r <= samp_v_nxt;
      samp_r <= samp_nxt;
      spd_r <= spd_nxt;
      stamp_r <= stamp_nxt;
      mark_r <= mark_nxt;
      prev_r <= prev_nxt;
      have_prev_r <= have_prev_nxt;
      est_r <= est_nxt;
      rate_cnt_r <= rate_cnt_nxt;
      win_r <= win_nxt;
      rate_ok_r <= rate_ok_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign RDATA_O = rdata_r;
  assign SAMPLE_O = samp_v_r;
  assign SAMPLE_DATA_O = samp_r;
  assign SAMPLE_SPEED_O = spd_r;
  assign STAMP_O = stamp_r;
  assign MARKED_O = mark_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_pin_gate;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
    !ctrl_r[odt_pkg::B_PIN_EN] |=> $stable(pin_cnt_r) || $past(WR_I);
  endproperty
  a_pin_gate: assert property (p_pin_gate) else $error("pin count moved");
  property p_single_edge;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
    (fall && !rise && !ctrl_r[odt_pkg::B_DUAL]) |=> $stable(pin_cnt_r);
  endproperty
  a_single_edge: assert property (p_single_edge) else $error("fall counted");
  property p_msg_pref;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
    (msg_any && !ctrl_r[odt_pkg::B_AMSG_DIS]) |-> src != odt_pkg::SRC_PIN;
  endproperty
  a_msg_pref: assert property (p_msg_pref) else $error("pin kept");
  property p_auto_spd;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
    (seen_s && !seen_t && !ctrl_r[odt_pkg::B_ASPD_DIS] &&
     !ctrl_r[odt_pkg::B_AMSG_DIS]) |-> src == odt_pkg::SRC_MSG_SPEED;
  endproperty
  a_auto_spd: assert property (p_auto_spd) else $error("speed not used");
  property p_tick_sel;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
    (seen_tick_r && !ctrl_r[odt_pkg::B_AMSG_DIS] &&
     !ctrl_r[odt_pkg::B_USE_SPD]) |-> src == odt_pkg::SRC_MSG_TICK;
  endproperty
  a_tick_sel: assert property (p_tick_sel) else $error("wrong type");
  property p_stamp_first;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
    (MSG_VALID_I && src == odt_pkg::SRC_MSG_SPEED &&
     MSG_TYPE_I == odt_pkg::TYPE_SPEED && !ctrl_r[odt_pkg::B_TMARK_MODE])
    |=> stamp_r == $past(first_ms_r) - $past(lat_r);
  endproperty
  a_stamp_first: assert property (p_stamp_first) else $error("bad stamp");
  property p_ms_period;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
    ms_tick |=> !ms_tick [*8];
  endproperty
  a_ms_period: assert property (p_ms_period) else $error("ms too fast");
  property p_wrap;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
    (ms_tick && ms_r >= tmax_r) |=> ms_r == 32'h0000_0000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap");
  c_pin: cover property (@(posedge CLK_SYS_I) tick_ev && src == odt_pkg::SRC_PIN);
  c_spd: cover property (@(posedge CLK_SYS_I) samp_v_r && spd_r);
  c_mark: cover property (@(posedge CLK_SYS_I) samp_v_r && mark_r);
endmodule
`default_nettype wire

/* bench/odt_sensor_model.sv */
/*
  Wheel sensor preprocessor model: tick and direction pins, time mark
  pulse and parsed measurement messages. Assumes the 40 MHz bench clock.
*/
`default_nettype none
module odt_sensor_model (
  input wire logic clk_i,
  output logic tick_o,
  output logic dir_o,
  output logic mark_o,
  output logic first_o,
  output logic valid_o,
  output logic [5:0] type_o,
  output logic rear_o,
  output logic [23:0] data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Idle levels
  // ----------------------------------------------------------------
  initial begin
    tick_o = 1'b0;
    dir_o = 1'b1;
    mark_o = 1'b0;
    first_o = 1'b0;
    valid_o = 1'b0;
    type_o = 6'h00;
    rear_o = 1'b0;
    data_o = 24'h000000;
  end
  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  // Even halves of five cycles: dual edge counting needs a square wave
  task automatic pulses(input int n);
    for (int i = 0; i < 2 * n; i++) begin
      @(posedge clk_i);
      tick_o <= ~tick_o;
      repeat (4) @(posedge clk_i);
    end
  endtask
  // Mark sent at measurement time, before its message
  task automatic mark();
    @(posedge clk_i);
    mark_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    mark_o <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // Messages
  // ----------------------------------------------------------------
  // Speed reaches the block only this way, in meters per second
  task automatic send(input logic [5:0] t, input logic r,
                      input logic [23:0] d);
    @(posedge clk_i);
    first_o <= 1'b1;
    @(posedge clk_i);
    first_o <= 1'b0;
    repeat (2) @(posedge clk_i);
    valid_o <= 1'b1;
    type_o <= t;
    rear_o <= r;
    data_o <= d;
    @(posedge clk_i);
    valid_o <= 1'b0;
    // Released lines show the inverse, never a stale match
    type_o <= ~t;
    rear_o <= ~r;
    data_o <= ~d;
  endtask
endmodule
`default_nettype wire

/* bench/tb_top.sv */
/*
  Self-checking bench for the odometer front end: register port, pins,
  messages and time tags. Assumes the sensor model on the message side.
*/
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [31:0] d;
    logic spd;
    logic mk;
    logic [31:0] st;
    bit cd;
  } odt_exp_t;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  localparam logic [31:0] PIN = 32'h1 << odt_pkg::B_PIN_EN;
  localparam logic [31:0] DUAL = 32'h1 << odt_pkg::B_DUAL;
  localparam logic [31:0] APOL = 32'h1 << odt_pkg::B_APOL_DIS;
  localparam logic [31:0] ASPD = 32'h1 << odt_pkg::B_ASPD_DIS;
  localparam logic [31:0] USPD = 32'h1 << odt_pkg::B_USE_SPD;
  localparam logic [31:0] COMB = 32'h1 << odt_pkg::B_COMBINE;
  localparam logic [31:0] ALIM = 32'h1 << odt_pkg::B_ALIM_DIS;
  localparam logic [31:0] TMRK = 32'h1 << odt_pkg::B_TMARK_MODE;
  localparam logic [31:0] TP1 = 32'h1 << odt_pkg::B_TP1_EN;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic tick, dir, mark, first, valid, rear, wr, rd, smp, sspd, marked;
  logic [5:0] mtype;
  logic [23:0] mdata;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, sdata, stamp, v0, v1;
  int mismatches = 0;
  int tests_run = 0;
  int cyc = 0;
  int lat = 0;
  int mark_ms = 0;
  bit tmode = 0;
  odt_exp_t expq[$];
  odt_exp_t ce;
  initial wr = 1'b0;
  initial rd = 1'b0;
  always #12.5 clk = ~clk;
  // ----------------------------------------------------------------
  // Instances
  // ----------------------------------------------------------------
  odt_sensor_model odt_sensor_model_inst (.clk_i(clk), .tick_o(tick),
    .dir_o(dir), .mark_o(mark), .first_o(first), .valid_o(valid),
    .type_o(mtype), .rear_o(rear), .data_o(mdata));
  odt_top odt_top_inst (.CLK_SYS_I(clk), .RESET_I(rst), .TICK_PIN_I(tick),
    .DIR_PIN_I(dir), .EXT_MARK_I(mark), .MSG_FIRST_I(first),
    .MSG_VALID_I(valid), .MSG_TYPE_I(mtype), .MSG_REAR_I(rear),
    .MSG_DATA_I(mdata), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdata), .SAMPLE_O(smp), .SAMPLE_DATA_O(sdata),
    .SAMPLE_SPEED_O(sspd), .STAMP_O(stamp), .MARKED_O(marked));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    if (mismatches == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    lat = 0;
    tmode = 0;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
    logic [31:0] v;
    rd_reg(a, v);
    check(v & m, e);
  endtask
  // Model: stamp is the millisecond of first byte or mark, less latency
  task automatic msg(input logic [5:0] t, input logic r, input logic [23:0] d,
                     input bit ok, input logic [31:0] ed, input bit cd);
    odt_exp_t e;
    e.d = ed;
    e.spd = (t == odt_pkg::TYPE_SPEED);
    e.mk = tmode;
    e.st = 32'((tmode ? mark_ms : cyc / odt_pkg::TTAG_CYC) - lat);
    e.cd = cd;
    if (ok) expq.push_back(e);
    odt_sensor_model_inst.send(t, r, d);
    repeat (3) @(posedge clk);
    check(32'(expq.size()), 32'h0);
    expq.delete();
  endtask
  task automatic m(input logic [5:0] t, input logic r, input bit ok);
    logic [23:0] d;
    d = 24'($urandom);
    msg(t, r, d, ok, {8'h00, d}, 1);
  endtask
  task automatic pin_delta(input int n, input logic [31:0] e);
    rd_reg(odt_pkg::ADR_TICKS, v0);
    odt_sensor_model_inst.pulses(n);
    repeat (6) @(posedge clk);
    rd_reg(odt_pkg::ADR_TICKS, v1);
    check(v1 - v0, e);
  endtask
  // ----------------------------------------------------------------
  // Sample compare and counters
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) cyc <= 0;
    else cyc <= cyc + 1;
    if (!rst && smp === 1'b1) begin
      if (expq.size() == 0) begin
        check(32'h1, 32'h0);
      end else begin
        ce = expq.pop_front();
        if (ce.cd) check(sdata, ce.d);
        check({31'h0, sspd}, {31'h0, ce.spd});
        check({31'h0, marked}, {31'h0, ce.mk});
        check(stamp, ce.st);
      end
    end
  end
  initial begin
    repeat (100000) @(posedge clk);
    check(32'h1, 32'h0);
    give_verdict();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int n;
    void'($urandom(32'hFDCD2DE4));
    do_reset();
    rd_chk(odt_pkg::ADR_LAT, ALL, 32'h0);
    rd_chk(odt_pkg::ADR_TTFACT, ALL, odt_pkg::TTFACT_RST);
    rd_chk(odt_pkg::ADR_TTMAX, ALL, odt_pkg::TTMAX_RST);
    rd_chk(odt_pkg::ADR_STAT, 32'h63, 32'h60);
    rd_chk(8'hF0, ALL, 32'h0);
    wr_reg(odt_pkg::ADR_TTFACT, 32'h7D0);
    rd_chk(odt_pkg::ADR_TTFACT, ALL, 32'h7D0);
    n = 1 + ($urandom % 8);
    pin_delta(n, 32'h0);
    wr_reg(odt_pkg::ADR_CTRL, PIN);
    pin_delta(n, 32'(n));
    rd_chk(odt_pkg::ADR_STAT, 32'h3, 32'h1);
    wr_reg(odt_pkg::ADR_CTRL, PIN | DUAL);
    pin_delta(n, 32'(2 * n));
    // Manual polarity low against a high direction pin counts down
    wr_reg(odt_pkg::ADR_CTRL, PIN | APOL);
    pin_delta(n, 32'(-n));
    wr_reg(odt_pkg::ADR_CTRL, PIN);
    m(odt_pkg::TYPE_SPEED, 1'b0, 1);
    rd_chk(odt_pkg::ADR_STAT, 32'h3, 32'h3);
    wr_reg(odt_pkg::ADR_CTRL, PIN | ASPD);
    m(odt_pkg::TYPE_SPEED, 1'b0, 0);
    wr_reg(odt_pkg::ADR_CTRL, PIN | ASPD | USPD);
    m(odt_pkg::TYPE_SPEED, 1'b0, 1);
    m(6'h05, 1'b0, 0);
    // Second reset clears what was seen on the message side
    do_reset();
    wr_reg(odt_pkg::ADR_LIMIT, odt_pkg::LIMIT_REL);
    m(odt_pkg::TYPE_TICK, 1'b0, 1);
    m(odt_pkg::TYPE_SPEED, 1'b0, 0);
    wr_reg(odt_pkg::ADR_CTRL, USPD);
    m(odt_pkg::TYPE_SPEED, 1'b0, 1);
    m(odt_pkg::TYPE_TICK, 1'b0, 0);
    wr_reg(odt_pkg::ADR_CTRL, COMB);
    m(odt_pkg::TYPE_TICK, 1'b0, 0);
    m(odt_pkg::TYPE_TICK, 1'b1, 1);
    wr_reg(odt_pkg::ADR_CTRL, ALIM);
    wr_reg(odt_pkg::ADR_LIMIT, 32'h3E7);
    msg(odt_pkg::TYPE_TICK, 1'b0, 24'd990, 1, 32'h0, 1);
    msg(odt_pkg::TYPE_TICK, 1'b0, 24'd5, 1, 32'd15, 1);
    msg(odt_pkg::TYPE_TICK, 1'b0, 24'd20, 1, 32'd15, 1);
    // Learnt limit: counts up to 1000 imply a 1024 roll-over
    wr_reg(odt_pkg::ADR_CTRL, 32'h0);
    wr_reg(odt_pkg::ADR_LIMIT, odt_pkg::LIMIT_AUTO);
    msg(odt_pkg::TYPE_TICK, 1'b0, 24'd1000, 1, 32'd980, 1);
    msg(odt_pkg::TYPE_TICK, 1'b0, 24'd3, 1, 32'd27, 1);
    rd_chk(odt_pkg::ADR_LIMIT, ALL, 32'h3FF);
    wr_reg(odt_pkg::ADR_LIMIT, odt_pkg::LIMIT_REL);
    wr_reg(odt_pkg::ADR_LAT, 32'h1);
    lat = 1;
    m(odt_pkg::TYPE_TICK, 1'b0, 1);
    wr_reg(odt_pkg::ADR_LAT, 32'h0);
    lat = 0;
    // Stamps taken a quarter into a millisecond, far from a tick of the time base
    while (cyc < 50000) @(posedge clk);
    m(odt_pkg::TYPE_TICK, 1'b0, 1);
    wr_reg(odt_pkg::ADR_LAT, 32'h1);
    lat = 1;
    m(odt_pkg::TYPE_TICK, 1'b0, 1);
    wr_reg(odt_pkg::ADR_CTRL, TMRK);
    while (cyc < 60000) @(posedge clk);
    mark_ms = cyc / odt_pkg::TTAG_CYC;
    odt_sensor_model_inst.mark();
    while (cyc < 85000) @(posedge clk);
    tmode = 1;
    m(odt_pkg::TYPE_TICK, 1'b0, 1);
    // Tick pin as the mark source while its tick use is off
    wr_reg(odt_pkg::ADR_CTRL, TMRK | TP1);
    mark_ms = cyc / odt_pkg::TTAG_CYC;
    odt_sensor_model_inst.pulses(1);
    m(odt_pkg::TYPE_TICK, 1'b0, 1);
    give_verdict();
  end
endmodule
`default_nettype wire
